// ---- rtl/pdm_pkg.sv ----
// package: offsets, field positions and reset values for the t1 pulse
// density monitor/enforcer; assumes 32-bit avalon-mm data, byte addressing
package pdm_pkg;

    // ------------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [9:0] GLOBAL_CFG_IDX = 10'h040;
    localparam logic [9:0] RX_DENSITY_IDX = 10'h043;
    localparam logic [9:0] TX_ENFORCE_IDX = 10'h045;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int E1_MODE_BIT      = 0;
    localparam int DENS_IRQ_EN_BIT  = 0;
    localparam int ZRUN_IRQ_EN_BIT  = 1;
    localparam int DENS_CHG_STS_BIT = 2;
    localparam int ZRUN_STS_BIT     = 3;
    localparam int LIVE_BIT         = 4;
    localparam int STUFF_STS_BIT    = 5;
    localparam int STUFF_EN_BIT     = 6;
    localparam int STUFF_IRQ_EN_BIT = 7;

    // ------------------------------------------------------------------
    // reset values and density criterion
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic       E1_MODE_RESET  = 1'b0;
    localparam int         DENS_WINDOW    = 192;
    localparam int         DENS_MIN_ONES  = 24;
    localparam int         ZERO_RUN_LEN   = 16;

endpackage

// ---- rtl/density_if.sv ----
// interface: bit stream into a density checker and its verdicts back out;
// assumes one bit per clock at most, marked by bit_valid
`timescale 1ns/1ps
`default_nettype none

interface density_if;
    logic bit_valid;
    logic bit_in;
    logic violation;
    logic change;
    logic zero_run;
    logic would_violate_zero;

    modport checker_side (
        input  bit_valid,
        input  bit_in,
        output violation,
        output change,
        output zero_run,
        output would_violate_zero
    );
    modport user_side (
        output bit_valid,
        output bit_in,
        input  violation,
        input  change,
        input  zero_run,
        input  would_violate_zero
    );
endinterface

`default_nettype wire

// ---- rtl/density_window.sv ----
// density checker over a sliding window of recent line bits;
// assumes bits arrive on core_clk with a valid strobe, in line order
`timescale 1ns/1ps
`default_nettype none

module density_window #(
    parameter int WINDOW   = pdm_pkg::DENS_WINDOW,
    parameter int MIN_ONES = pdm_pkg::DENS_MIN_ONES,
    parameter int ZRUN     = pdm_pkg::ZERO_RUN_LEN
) (
    // clock, reset, enable
    input  wire logic               core_clk,
    input  wire logic               rstn,
    input  wire logic               ce,
    input  wire logic               clear,
    // stream and verdicts
    density_if.checker_side         dif
);
    localparam int CW = $clog2(WINDOW + 1);
    localparam int ZW = $clog2(ZRUN + 1);
    localparam logic [CW-1:0] MIN_C  = CW'(MIN_ONES);
    localparam logic [ZW-1:0] ZRUN_C = ZW'(ZRUN);

    logic [WINDOW-1:0] hist_reg;
    logic [CW-1:0]     ones_reg;
    logic [ZW-1:0]     zrun_reg;
    logic              viol_reg;
    logic              chg_reg;
    logic              z16_reg;
    logic [CW-1:0]     ones_next;
    logic [ZW-1:0]     zrun_next;
    logic              viol_next;

    // --------------------------------------------------------------
    // next window state for the incoming bit
    // --------------------------------------------------------------
    // history starts all ones so a fresh line is not flagged at once
    always_comb begin
        ones_next = ones_reg + CW'(dif.bit_in)
                  - CW'(hist_reg[WINDOW-1]);
        zrun_next = dif.bit_in ? '0
                  : (zrun_reg == ZRUN_C ? zrun_reg : zrun_reg + 1'b1);
        viol_next = (ones_next < MIN_C) || (zrun_next == ZRUN_C); // see RULE15
    end

    assign dif.would_violate_zero =
        (ones_reg - CW'(hist_reg[WINDOW-1]) < MIN_C) ||
        (zrun_reg >= ZRUN_C - 1'b1);
    assign dif.violation = viol_reg;
    assign dif.change    = chg_reg;
    assign dif.zero_run  = z16_reg;

    // --------------------------------------------------------------
    // window, counters and verdicts
    // --------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hist_reg <= '1;
            ones_reg <= CW'(WINDOW);
            zrun_reg <= '0;
            viol_reg <= 1'b0;
            chg_reg  <= 1'b0;
            z16_reg  <= 1'b0;
        end else if (ce) begin
            if (clear) begin
                hist_reg <= '1;
                ones_reg <= CW'(WINDOW);
                zrun_reg <= '0;
                viol_reg <= 1'b0;
                chg_reg  <= 1'b0;
                z16_reg  <= 1'b0;
            end else begin
                chg_reg <= dif.bit_valid && (viol_next != viol_reg);
                z16_reg <= dif.bit_valid && (zrun_next == ZRUN_C)
                         && (zrun_reg == ZRUN_C - 1'b1);
                if (dif.bit_valid) begin
                    hist_reg <= {hist_reg[WINDOW-2:0], dif.bit_in};
                    ones_reg <= ones_next;
                    zrun_reg <= zrun_next;
                    viol_reg <= viol_next;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ---- rtl/t1_pulse_density_monitor_enforcer.sv ----
// top: receive density detector, transmit density enforcer, registers on
// avalon-mm; assumes line bit streams come from logic on core_clk
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1: e1 mode holds both registers in reset
// RULE2: live indicator follows current violation state
// RULE3: change status sets on edges, read clears
// RULE4: zero-run status sets on sixteen zeros
// RULE5: statuses latch regardless of enables
// RULE6: zero-run enable gates interrupt output
// RULE7: density enable interrupts on start, end
// RULE8: stuff enable makes stuffs interrupt
// RULE9: stuffing enabled forces ones preventing violations
// RULE10: stuffing off passes data, reports changes
// RULE11: stuff status sets, read clears it
// RULE12: stuffing on forces tx statuses zero
// RULE13: tx density interrupt only without stuff enable
// RULE14: interrupt output active low until read
// RULE15: ones density over sliding window, per bit
module t1_pulse_density_monitor_enforcer (
    // clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // avalon-mm slave
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // receive line stream
    input  wire logic        rx_bit_valid,
    input  wire logic        rx_bit,
    // transmit pcm stream
    input  wire logic        tx_in_valid,
    input  wire logic        tx_in_bit,
    output var  logic        tx_out_valid,
    output var  logic        tx_out_bit,
    // interrupt
    output var  logic        irq_out_n
);
    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    logic        e1_mode_reg;
    logic        ack_reg;
    logic        rx_den_ie_reg;
    logic        rx_zr_ie_reg;
    logic        rx_chg_sts_reg;
    logic        rx_zr_sts_reg;
    logic        tx_den_ie_reg;
    logic        tx_zr_ie_reg;
    logic        tx_chg_sts_reg;
    logic        tx_zr_sts_reg;
    logic        tx_stuff_sts_reg;
    logic        stuff_en_reg;
    logic        stuff_ie_reg;
    logic        irq_next;
    logic        accept;
    logic        wr_acc;
    logic        rd_acc;
    logic        stuff_now;
    logic [9:0]  idx;
    logic [7:0]  rx_view;
    logic [7:0]  tx_view;

    density_if rx_dif ();
    density_if tx_dif ();

    function automatic logic hit(input logic [9:0] a, input logic [9:0] i);
        hit = (a == i);
    endfunction

    // --------------------------------------------------------------
    // bus handshake
    // --------------------------------------------------------------
    // one wait cycle per access: readdata is captured in it, so the
    // accepting edge never sees a half-decoded value
    assign idx             = avs_address[11:2];
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
    assign accept          = (avs_read || avs_write) && ack_reg && ce;
    assign wr_acc          = accept && avs_write && avs_byteenable[0];
    assign rd_acc          = accept && avs_read;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ack_reg <= 1'b0;
        end else if (ce) begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end

    // --------------------------------------------------------------
    // checkers
    // --------------------------------------------------------------
    assign rx_dif.bit_valid = rx_bit_valid;
    assign rx_dif.bit_in    = rx_bit;
    // zero replaced by one only when it would break density
    assign stuff_now = stuff_en_reg && tx_in_valid && !tx_in_bit
                     && tx_dif.would_violate_zero && !e1_mode_reg; // see RULE9
    assign tx_dif.bit_valid = tx_in_valid;
    assign tx_dif.bit_in    = tx_in_bit || stuff_now;

    density_window u_rx_check (
        .core_clk (core_clk),
        .rstn     (rstn),
        .ce       (ce),
        .clear    (e1_mode_reg),
        .dif      (rx_dif)
    );

    density_window u_tx_check (
        .core_clk (core_clk),
        .rstn     (rstn),
        .ce       (ce),
        .clear    (e1_mode_reg),
        .dif      (tx_dif)
    );

    // --------------------------------------------------------------
    // global configuration
    // --------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            e1_mode_reg <= pdm_pkg::E1_MODE_RESET;
        end else if (ce && wr_acc && hit(idx, pdm_pkg::GLOBAL_CFG_IDX)) begin
            e1_mode_reg <= avs_writedata[pdm_pkg::E1_MODE_BIT];
        end
    end

    // --------------------------------------------------------------
    // receive detector register
    // --------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_den_ie_reg  <= pdm_pkg::CTRL_RESET[0];
            rx_zr_ie_reg   <= pdm_pkg::CTRL_RESET[1];
            rx_chg_sts_reg <= 1'b0;
            rx_zr_sts_reg  <= 1'b0;
        end else if (ce) begin
            if (e1_mode_reg) begin // see RULE1
                rx_den_ie_reg  <= 1'b0;
                rx_zr_ie_reg   <= 1'b0;
                rx_chg_sts_reg <= 1'b0;
                rx_zr_sts_reg  <= 1'b0;
            end else begin
                if (wr_acc && hit(idx, pdm_pkg::RX_DENSITY_IDX)) begin
                    rx_den_ie_reg <= avs_writedata[pdm_pkg::DENS_IRQ_EN_BIT];
                    rx_zr_ie_reg  <= avs_writedata[pdm_pkg::ZRUN_IRQ_EN_BIT];
                end
                // set wins over the read clear; no enable gating
                rx_chg_sts_reg <= rx_dif.change || (rx_chg_sts_reg &&
                    !(rd_acc && hit(idx, pdm_pkg::RX_DENSITY_IDX))); // see RULE3 RULE5
                rx_zr_sts_reg <= rx_dif.zero_run || (rx_zr_sts_reg &&
                    !(rd_acc && hit(idx, pdm_pkg::RX_DENSITY_IDX))); // see RULE4 RULE5
            end
        end
    end

    // --------------------------------------------------------------
    // transmit enforcer register
    // --------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_den_ie_reg    <= 1'b0;
            tx_zr_ie_reg     <= 1'b0;
            stuff_en_reg     <= 1'b0;
            stuff_ie_reg     <= 1'b0;
            tx_chg_sts_reg   <= 1'b0;
            tx_zr_sts_reg    <= 1'b0;
            tx_stuff_sts_reg <= 1'b0;
        end else if (ce) begin
            if (e1_mode_reg) begin // see RULE1
                tx_den_ie_reg    <= 1'b0;
                tx_zr_ie_reg     <= 1'b0;
                stuff_en_reg     <= 1'b0;
                stuff_ie_reg     <= 1'b0;
                tx_chg_sts_reg   <= 1'b0;
                tx_zr_sts_reg    <= 1'b0;
                tx_stuff_sts_reg <= 1'b0;
            end else begin
                if (wr_acc && hit(idx, pdm_pkg::TX_ENFORCE_IDX)) begin
                    tx_den_ie_reg <= avs_writedata[pdm_pkg::DENS_IRQ_EN_BIT];
                    tx_zr_ie_reg  <= avs_writedata[pdm_pkg::ZRUN_IRQ_EN_BIT];
                    stuff_en_reg  <= avs_writedata[pdm_pkg::STUFF_EN_BIT];
                    stuff_ie_reg  <= avs_writedata[pdm_pkg::STUFF_IRQ_EN_BIT];
                end
                if (stuff_en_reg) begin // see RULE12
                    tx_chg_sts_reg <= 1'b0;
                    tx_zr_sts_reg  <= 1'b0;
                end else begin
                    tx_chg_sts_reg <= tx_dif.change || (tx_chg_sts_reg &&
                        !(rd_acc && hit(idx, pdm_pkg::TX_ENFORCE_IDX))); // see RULE10
                    tx_zr_sts_reg <= tx_dif.zero_run || (tx_zr_sts_reg &&
                        !(rd_acc && hit(idx, pdm_pkg::TX_ENFORCE_IDX))); // see RULE5
                end
                tx_stuff_sts_reg <= stuff_now || (tx_stuff_sts_reg &&
                    !(rd_acc && hit(idx, pdm_pkg::TX_ENFORCE_IDX))); // see RULE11
            end
        end
    end

    // --------------------------------------------------------------
    // read views and read data
    // --------------------------------------------------------------
    always_comb begin
        rx_view = 8'h00;
        rx_view[pdm_pkg::DENS_IRQ_EN_BIT]  = rx_den_ie_reg;
        rx_view[pdm_pkg::ZRUN_IRQ_EN_BIT]  = rx_zr_ie_reg;
        rx_view[pdm_pkg::DENS_CHG_STS_BIT] = rx_chg_sts_reg;
        rx_view[pdm_pkg::ZRUN_STS_BIT]     = rx_zr_sts_reg;
        rx_view[pdm_pkg::LIVE_BIT]         = rx_dif.violation; // see RULE2
        tx_view = 8'h00;
        tx_view[pdm_pkg::DENS_IRQ_EN_BIT]  = tx_den_ie_reg;
        tx_view[pdm_pkg::ZRUN_IRQ_EN_BIT]  = tx_zr_ie_reg;
        tx_view[pdm_pkg::DENS_CHG_STS_BIT] = tx_chg_sts_reg;
        tx_view[pdm_pkg::ZRUN_STS_BIT]     = tx_zr_sts_reg;
        tx_view[pdm_pkg::LIVE_BIT] = tx_dif.violation && !stuff_en_reg; // see RULE12
        tx_view[pdm_pkg::STUFF_STS_BIT]    = tx_stuff_sts_reg;
        tx_view[pdm_pkg::STUFF_EN_BIT]     = stuff_en_reg;
        tx_view[pdm_pkg::STUFF_IRQ_EN_BIT] = stuff_ie_reg;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (ce && avs_read && !ack_reg) begin
            case (1'b1)
                hit(idx, pdm_pkg::GLOBAL_CFG_IDX):
                    avs_readdata <= {31'h0000_0000, e1_mode_reg};
                hit(idx, pdm_pkg::RX_DENSITY_IDX):
                    avs_readdata <= {24'h00_0000, rx_view};
                hit(idx, pdm_pkg::TX_ENFORCE_IDX):
                    avs_readdata <= {24'h00_0000, tx_view};
                default:
                    avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // --------------------------------------------------------------
    // transmit output and interrupt
    // --------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_out_valid <= 1'b0;
            tx_out_bit   <= 1'b0;
        end else if (ce) begin
            tx_out_valid <= tx_in_valid;
            tx_out_bit   <= tx_in_bit || stuff_now; // see RULE9 RULE10
        end
    end

    assign irq_next = (rx_zr_sts_reg && rx_zr_ie_reg)            // see RULE6
                   || (rx_chg_sts_reg && rx_den_ie_reg)          // see RULE7
                   || (tx_zr_sts_reg && tx_zr_ie_reg)
                   || (tx_chg_sts_reg && tx_den_ie_reg && !stuff_ie_reg) // see RULE13
                   || (tx_stuff_sts_reg && stuff_ie_reg);        // see RULE8

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_out_n <= 1'b1;
        end else if (ce) begin
            irq_out_n <= !irq_next; // see RULE14
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    sequence rx_read_taken;
        rd_acc && hit(idx, pdm_pkg::RX_DENSITY_IDX) && !e1_mode_reg;
    endsequence
    sequence quiet_rx;
        !rx_dif.change && !rx_dif.zero_run;
    endsequence

    AST_E1_HOLD: assert property (@(posedge core_clk) disable iff (!rstn) // see RULE1
        ce && e1_mode_reg |=> rx_view[3:0] == 4'h0 && tx_view == 8'h00)
        else $error("e1 mode did not hold registers in reset");
    AST_READ_CLEARS: assert property (@(posedge core_clk) disable iff (!rstn) // see RULE3
        rx_read_taken ##0 quiet_rx |=> !rx_chg_sts_reg && !rx_zr_sts_reg)
        else $error("read did not clear receive status");
    AST_CHANGE_SETS: assert property (@(posedge core_clk) disable iff (!rstn) // see RULE5
        ce && !e1_mode_reg && rx_dif.change |=> rx_chg_sts_reg)
        else $error("density change not latched");
    AST_ZRUN_IRQ: assert property (@(posedge core_clk) disable iff (!rstn) // see RULE6
        ce && !e1_mode_reg && rx_zr_ie_reg && rx_dif.zero_run
        ##1 ce |=> !irq_out_n)
        else $error("zero run did not pull interrupt low");
    AST_IRQ_QUIET: assert property (@(posedge core_clk) disable iff (!rstn) // see RULE14
        ce && !rx_den_ie_reg && !rx_zr_ie_reg && !tx_den_ie_reg
        && !tx_zr_ie_reg && !stuff_ie_reg |=> irq_out_n)
        else $error("interrupt asserted with all enables off");
    AST_STUFF_ONE: assert property (@(posedge core_clk) disable iff (!rstn) // see RULE9
        ce && stuff_now |=> tx_out_bit && tx_out_valid && tx_stuff_sts_reg)
        else $error("stuff bit not inserted or not reported");
    AST_PASS_THRU: assert property (@(posedge core_clk) disable iff (!rstn) // see RULE10
        ce && !stuff_en_reg && tx_in_valid |=> tx_out_bit == $past(tx_in_bit))
        else $error("pcm altered with stuffing off");
    AST_STUFF_QUIET: assert property (@(posedge core_clk) disable iff (!rstn) // see RULE12
        ce && stuff_en_reg ##1 stuff_en_reg |-> !tx_chg_sts_reg
        && !tx_zr_sts_reg && !tx_view[pdm_pkg::LIVE_BIT])
        else $error("tx status not forced low while stuffing");
    AST_TX_MASK: assert property (@(posedge core_clk) disable iff (!rstn) // see RULE13
        ce && stuff_ie_reg && !tx_stuff_sts_reg && !rx_view[2] && !rx_view[3]
        && !tx_zr_sts_reg |=> irq_out_n)
        else $error("tx density change interrupted with stuff enable set");

endmodule

`default_nettype wire

// ---- verification/pcm_source.sv ----
// partner: t1 pcm bit source feeding one density stream of the block
// assumes the core_clk domain; bits change only after a rising edge
`timescale 1ns/1ps
`default_nettype none

module pcm_source (
    // clock, reset
    input  wire logic core_clk,
    input  wire logic rstn,
    // control from the bench
    input  wire logic run,
    input  wire logic zeros,
    input  wire logic slow,
    // bit stream
    output var  logic bit_valid,
    output var  logic bit_out
);
    logic ph;

    // idle bit toggles so a stale value is never mistaken for data
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ph        <= 1'b0;
            bit_valid <= 1'b0;
            bit_out   <= 1'b0;
        end else begin
            ph        <= !ph;
            bit_valid <= run & (!slow | ph);
            bit_out   <= (run & (!slow | ph)) ? !zeros : !bit_out;
        end
    end
endmodule

`default_nettype wire

// ---- verification/t1_pulse_density_monitor_enforcer_test.sv ----
// testbench: register accesses and line streams against the density block
// assumes pcm_source as the far side and avalon-mm register access
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end

module t1_pulse_density_monitor_enforcer_test;
    localparam logic [11:0] rx_a = {pdm_pkg::RX_DENSITY_IDX, 2'b00};
    localparam logic [11:0] tx_a = {pdm_pkg::TX_ENFORCE_IDX, 2'b00};
    localparam logic [11:0] cf_a = {pdm_pkg::GLOBAL_CFG_IDX, 2'b00};
    logic        core_clk = 1'b0;
    logic        rstn     = 1'b0;
    logic        ce       = 1'b1;
    logic [11:0] avs_address = 12'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        rx_run = 1'b0, rx_zero = 1'b0, slow = 1'b0;
    logic        tx_run = 1'b0, tx_zero = 1'b0;
    logic        rx_bit_valid, rx_bit, tx_in_valid, tx_in_bit;
    logic        tx_out_valid, tx_out_bit, irq_out_n;
    int          err_total = 0, checked = 0, cycles = 0;
    int          run_len = 0, max_run = 0;

    always #4 core_clk = !core_clk;

    t1_pulse_density_monitor_enforcer DUT (
        .core_clk(core_clk), .rstn(rstn), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
        .tx_in_valid(tx_in_valid), .tx_in_bit(tx_in_bit),
        .tx_out_valid(tx_out_valid), .tx_out_bit(tx_out_bit),
        .irq_out_n(irq_out_n));
    pcm_source rx_src (.core_clk(core_clk), .rstn(rstn), .run(rx_run),
        .zeros(rx_zero), .slow(slow), .bit_valid(rx_bit_valid),
        .bit_out(rx_bit));
    pcm_source tx_src (.core_clk(core_clk), .rstn(rstn), .run(tx_run),
        .zeros(tx_zero), .slow(1'b0), .bit_valid(tx_in_valid),
        .bit_out(tx_in_bit));

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic wrap_up();
        $display("checked %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // request held until waitrequest is sampled low at a rising edge;
    // the iff looks at the value from before that edge's updates
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        @(posedge core_clk iff (avs_waitrequest === 1'b0));
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input string n);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, q);
        `CHK(n, e, q)
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // settled view of the interrupt pin, away from the sampling edge
    task automatic irq_is(input logic e);
        @(negedge core_clk);
        `CHK("irq_out_n", e, irq_out_n)
    endtask

    always @(negedge core_clk) begin
        if (tx_out_valid === 1'b1)
            run_len = (tx_out_bit === 1'b1) ? 0 : run_len + 1;
        if (run_len > max_run)
            max_run = run_len;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    initial begin
        cyc(5);
        rstn <= 1'b1;
        rd(rx_a, 32'h00, "rx_reset");
        rd(12'h200, 32'h00, "unmapped");
        wr(rx_a, 32'h03);
        rx_zero <= 1'b1;
        rx_run  <= 1'b1;
        slow    <= 1'b1;
        cyc(50);
        irq_is(1'b0);
        rd(rx_a, 32'h1f, "rx_zero_run");
        rd(rx_a, 32'h13, "rx_read_clear");
        cyc(3);
        irq_is(1'b1);
        rx_zero <= 1'b0;
        cyc(12);
        irq_is(1'b0);
        rd(rx_a, 32'h07, "rx_viol_end");
        wr(rx_a, 32'h00);
        rx_zero <= 1'b1;
        slow    <= 1'b0;
        cyc(40);
        irq_is(1'b1);
        rd(rx_a, 32'h1c, "rx_no_enable");
        rx_zero <= 1'b0;
        cyc(4);
        rd(rx_a, 32'h04, "rx_chg_no_irq");
        wr(tx_a, 32'h01);
        tx_zero <= 1'b1;
        tx_run  <= 1'b1;
        cyc(24);
        irq_is(1'b0);
        `CHK("tx_pass", 1'b0, tx_out_bit)
        rd(tx_a, 32'h1d, "tx_pass_sts");
        tx_zero <= 1'b0;
        cyc(30);
        rd(tx_a, 32'h05, "tx_viol_end");
        wr(tx_a, 32'h81);
        tx_zero <= 1'b1;
        cyc(24);
        irq_is(1'b1);
        rd(tx_a, 32'h9d, "tx_masked_chg");
        tx_zero <= 1'b0;
        cyc(20);
        irq_is(1'b1);
        wr(tx_a, 32'hc1);
        max_run = 0;
        tx_zero <= 1'b1;
        cyc(60);
        tx_run <= 1'b0;
        cyc(4);
        `CHK("tx_max_zero_run", 1'b1, max_run < 16)
        irq_is(1'b0);
        rd(tx_a, 32'he1, "tx_stuffed");
        cyc(3);
        irq_is(1'b1);
        rd(tx_a, 32'hc1, "tx_stuff_clear");
        wr(tx_a, 32'h40);
        tx_run <= 1'b1;
        cyc(40);
        irq_is(1'b1);
        tx_run <= 1'b0;
        cyc(4);
        rd(tx_a, 32'h60, "tx_stuff_noirq");
        // zeros offered while frozen must not be counted
        ce      <= 1'b0;
        rx_zero <= 1'b1;
        cyc(30);
        ce      <= 1'b1;
        rx_zero <= 1'b0;
        cyc(4);
        rd(rx_a, 32'h00, "rx_ce_frozen");
        wr(cf_a, 32'h01);
        rd(rx_a, 32'h00, "rx_e1_hold");
        rd(tx_a, 32'h00, "tx_e1_hold");
        wr(rx_a, 32'h03);
        rd(rx_a, 32'h00, "rx_e1_write");
        wr(cf_a, 32'h00);
        rd(cf_a, 32'h00, "cfg_back");
        wrap_up();
    end
endmodule

`default_nettype wire
